// ===== bench/cml_mem_model.sv
`timescale 1ns/1ps
module cml_mem_model
	import cml_pkg::*;
(
	// Core clock, time base only
	input  wire logic       core_clk_i,
	// Loader's own clock in self-driven mode
	input  wire logic       load_clock_i,
	input  wire logic       load_clock_oe_i,
	input  wire logic       auto_en_i,
	// Link towards the loader
	output logic            link_clk_o,
	output logic [7:0]      data_o
);
	// Image served on the loader's clock, first byte in the low half
	localparam logic [15:0] AUTO_IMG = 16'hC53C;
	int   bit_idx;
	logic clk_q;
	logic oe_q;

	// Link clock rests low, data starts at a neutral value
	initial begin
		link_clk_o = 1'b0;
		data_o = 8'h00;
		bit_idx = 0;
		clk_q = 1'b0;
		oe_q = 1'b0;
	end

	// serve image bits
	// First bit when the loader selects us, next one after each fall
	always @(posedge core_clk_i) begin
		clk_q <= load_clock_i;
		oe_q <= load_clock_oe_i;
		if (auto_en_i && load_clock_oe_i) begin
			if (!oe_q) begin
				data_o[0] <= AUTO_IMG[bit_idx];
			end else if (clk_q && !load_clock_i && bit_idx < 15) begin
				data_o[0] <= AUTO_IMG[bit_idx+1];
				bit_idx <= bit_idx + 1;
			end
		end else if (auto_en_i) begin
			// Not selected: a line nobody drives, so keep it moving
			data_o <= ~data_o;
		end
	end

	// serial frame, bit 0 first, clock only inside the frame
	task automatic send_bits(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk_i);
			data_o[0] <= b[i];
			repeat (7) @(posedge core_clk_i);
			link_clk_o <= 1'b1;
			repeat (8) @(posedge core_clk_i);
			link_clk_o <= 1'b0;
		end
		@(posedge core_clk_i);
		data_o <= ~data_o;
	endtask

	// one word held across n link clock rises
	task automatic send_par(input logic [7:0] w, input int n);
		@(posedge core_clk_i);
		data_o <= w;
		repeat (n) begin
			repeat (8) @(posedge core_clk_i);
			link_clk_o <= 1'b1;
			repeat (8) @(posedge core_clk_i);
			link_clk_o <= 1'b0;
		end
		@(posedge core_clk_i);
		data_o <= ~data_o;
	endtask
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb
	import cml_pkg::*;
;
	logic        clk;
	logic        rst;
	cml_av_req_t req;
	cml_pins_t   pins;
	logic        rsel, pud, bsel, ce_n, rl_n, auto_en;
	logic        link_clk;
	logic [7:0]  link_data;
	logic        wait_o, lclk, lclk_oe, ceo_n, stat_o, io_oe;
	logic        pu_en, lvb, cmd, ures, we;
	logic [31:0] rdata;
	logic [7:0]  wdata;
	logic [7:0]  got_q[$];
	int          fails, compares, cyc;

	assign pins = {rsel, pud, bsel, ce_n, rl_n, link_clk, link_data};

	// Short power-on counts keep the run brief
	cml_loader #(.POR_LONG_CYC(200), .POR_SHORT_CYC(50)) dut (
		.core_clk_i(clk), .rst_i(rst), .av_i(req),
		.av_waitrequest_o(wait_o), .av_readdata_o(rdata), .pins_i(pins),
		.load_clock_o(lclk), .load_clock_oe_o(lclk_oe),
		.chain_load_enable_out_n_o(ceo_n), .load_status_out_o(stat_o),
		.io_oe_o(io_oe), .pullup_en_o(pu_en), .low_voltage_buffer_o(lvb),
		.cmd_mode_o(cmd), .user_reset_o(ures), .cfg_we_o(we),
		.cfg_wdata_o(wdata));

	cml_mem_model mem (
		.core_clk_i(clk), .load_clock_i(lclk), .load_clock_oe_i(lclk_oe),
		.auto_en_i(auto_en), .link_clk_o(link_clk), .data_o(link_data));

	// Core clock, 4 ns
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Cycles since the last reset release
	always @(posedge clk or posedge rst) begin
		if (rst) cyc <= 0;
		else cyc <= cyc + 1;
	end

	// Collect every configuration word written
	always @(posedge clk) begin
		if (!rst && we === 1'b1) got_q.push_back(wdata);
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic results();
		$display("counts: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// I/O may only drive outside command mode
	always @(negedge clk) begin
		if (!rst && io_oe === 1'b1) chk(32'(cmd), 32'h0);
	end

	// One Avalon transfer; entered and left just after a rising edge
	task automatic bus(input logic wr_en, input logic [5:0] a,
		input logic [31:0] wd, output logic [31:0] rd_v);
		int n;
		n = 0;
		req.read <= !wr_en;
		req.write <= wr_en;
		req.address <= a;
		req.writedata <= wd;
		@(posedge clk);
		while (wait_o !== 1'b0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		// A request that is never answered counts against the run
		if (n >= 200) fails++;
		rd_v = rdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x & m, e);
	endtask

	// Bounded wait for the loader's own clock to start
	task automatic por_wait(input int lo, input int hi);
		int n;
		n = 0;
		while (lclk_oe !== 1'b1 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		chk(32'(cyc >= lo && cyc <= hi), 32'h1);
	endtask

	// Wait for user mode, then compare the two words written
	task automatic chk_words(input logic [7:0] e0, input logic [7:0] e1);
		int n;
		n = 0;
		while (io_oe !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		chk(32'(io_oe), 32'h1);
		chk(32'(got_q.size()), 32'h2);
		chk({24'h0, got_q[0]}, {24'h0, e0});
		chk({24'h0, got_q[1]}, {24'h0, e1});
	endtask

	// Pin reload with a new control word
	task automatic reload(input logic [31:0] ctrl);
		wr(CML_REG_CTRL, ctrl);
		got_q.delete();
		rl_n <= 1'b0;
		repeat (5) @(posedge clk);
		chk(32'(cmd), 32'h1);
		chk(32'(io_oe), 32'h0);
		chk(32'(ceo_n), 32'h1);
		chk(32'(pu_en), {31'h0, ~pud});
		rl_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	// Main sequence
	initial begin
		rst = 1'b1;
		req = '0;
		rsel = 1'b1;
		pud = 1'b0;
		bsel = 1'b1;
		ce_n = 1'b0;
		rl_n = 1'b1;
		auto_en = 1'b1;
		fails = 0;
		compares = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(32'(io_oe), 32'h0);
		chk(32'(pu_en), 32'h1);
		wr(CML_REG_LENGTH, 32'h2);
		rd(CML_REG_STATUS, 32'h7F, 32'h41);
		por_wait(50, 60);
		chk_words(8'h3C, 8'hC5);
		auto_en <= 1'b0;
		rd(CML_REG_STATUS, 32'hFFF, 32'h890);
		$display("test power-up load done");
		for (int s = 0; s < 5; s++) begin
			wr(CML_REG_CTRL, 32'(s));
			rd(CML_REG_CTRL, 32'h7, 32'(s));
		end
		wr(6'h24, 32'hFFFF_FFFF);
		rd(6'h24, 32'hFFFF_FFFF, 32'h0);
		wr(CML_REG_CTRL, 32'hC1);
		rd(CML_REG_STATUS, 32'h200, 32'h0);
		wr(CML_REG_CTRL, 32'h82);
		rd(CML_REG_STATUS, 32'h200, 32'h200);
		wr(CML_REG_CTRL, 32'h102);
		chk(32'(stat_o), 32'h0);
		rd(CML_REG_STATUS, 32'h400, 32'h400);
		wr(CML_REG_CTRL, 32'h202);
		chk(32'(stat_o), 32'h1);
		$display("test registers done");
		// Buffer select moves after power-up and must be ignored
		bsel <= 1'b0;
		pud <= 1'b1;
		reload(32'h4);
		ce_n <= 1'b1;
		mem.send_bits(8'h11);
		chk(32'(got_q.size()), 32'h0);
		ce_n <= 1'b0;
		mem.send_bits(8'h5E);
		mem.send_bits(8'h7B);
		chk_words(8'h5E, 8'h7B);
		chk(32'(lvb), 32'h1);
		chk(32'(ceo_n), 32'h0);
		pud <= 1'b0;
		$display("test serial reload done");
		reload(32'h0A);
		mem.send_bits(8'h81);
		chk_words(8'h00, 8'h00);
		reload(32'h08);
		mem.send_par(8'h12, 4);
		mem.send_par(8'h34, 4);
		chk_words(8'h12, 8'h34);
		reload(32'h28);
		mem.send_par(8'h56, 1);
		mem.send_par(8'h9A, 1);
		chk_words(8'h56, 8'h9A);
		// Soft reload, armed by the remote bit already stored
		wr(CML_REG_CTRL, 32'h4B);
		got_q.delete();
		wr(CML_REG_CTRL, 32'h44B);
		rd(CML_REG_STATUS, 32'h3F, 32'h02);
		wr(CML_REG_DATA, 32'hF0);
		wr(CML_REG_DATA, 32'h87);
		chk_words(8'hF0, 8'h87);
		$display("test schemes done");
		// All-zero key leaves the header unchanged, and it is wrong
		for (int k = 0; k < 4; k++) wr(CML_REG_KEY + 6'(4 * k), 32'h0);
		reload(32'h12);
		mem.send_bits(8'h5A);
		repeat (10) @(posedge clk);
		chk(32'(stat_o), 32'h0);
		rd(CML_REG_STATUS, 32'h100, 32'h100);
		$display("test bad key done");
		rsel <= 1'b0;
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(32'(cmd), 32'h1);
		chk(32'(io_oe), 32'h0);
		por_wait(200, 210);
		$display("test long power-on done");
		results();
	end

	// Watchdog, well beyond the expected run length
	initial begin
		#300000;
		fails++;
		$display("watchdog expired at %0t", $time);
		results();
	end
endmodule

// ===== logic/cml_div.sv
`timescale 1ns/1ps
module cml_div
	import cml_pkg::*;
#(
	parameter int HALF = CML_SERIAL_HALF_CYC
) (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	// Run control
	input  wire logic en_i,
	// Divided clock and its rising-edge pulse
	output logic      clk_o,
	output logic      rise_o
);
	localparam int CW = $clog2(HALF + 1);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          clk;
		logic          rise;
	} cml_div_t;

	cml_div_t s;
	cml_div_t next_s;

	if (HALF < 1) begin : g_chk
		$error("cml_div: HALF must be at least 1");
	end

	// Clock parks low when stopped, so a restart begins cleanly
	always_comb begin
		next_s      = s;
		next_s.rise = 1'b0;
		if (!en_i) begin
			next_s.cnt = '0;
			next_s.clk = 1'b0;
		end else if (s.cnt == CW'(HALF - 1)) begin
			next_s.cnt  = '0;
			next_s.clk  = !s.clk;
			next_s.rise = !s.clk;
		end else begin
			next_s.cnt = s.cnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign clk_o  = s.clk;
	assign rise_o = s.rise;
endmodule

// ===== logic/cml_loader.sv
// How it works
// - Every power-up reloads; user mode only after a full image is written.
// - After loading, an initialization phase resets logic, then user mode.
// - I/O outputs stay disabled from power-up until initialization ends.
// - Reload pin leaves user mode, reloads, re-initializes, resumes.
// - Power-on delay is 100 ms with select low, 12 ms with it high.
// - Weak pull-ups on before and during loading unless disable pin high.
// - Input buffer select is latched once at power-up, never again.
// - Exactly one of five loading schemes is chosen in control register.
// - Enable-in gates data taking; enable-out asserts when this device is done.
// - Self-driven serial supports remote update only, never local update.
// - Parallel data from an enhanced memory bypasses our decompressor.
// - Compressed runs are expanded on the fly into configuration writes.
// - A processor loads words by writing one memory-mapped data register.
// - Self-driven serial loads on its own from memory after power-up.
// - Held I/O configuration keeps status low until update is written.
// - Encrypted streams must decrypt with the stored 128-bit key; same size.
`timescale 1ns/1ps
module cml_loader
	import cml_pkg::*;
#(
	parameter int POR_LONG_CYC  = CML_POR_LONG_CYC,
	parameter int POR_SHORT_CYC = CML_POR_SHORT_CYC
) (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// Avalon-MM slave
	input  wire cml_av_req_t av_i,
	output logic             av_waitrequest_o,
	output logic [31:0]      av_readdata_o,
	// Configuration pins
	input  wire cml_pins_t   pins_i,
	output logic             load_clock_o,
	output logic             load_clock_oe_o,
	output logic             chain_load_enable_out_n_o,
	output logic             load_status_out_o,
	// Pin and fabric control
	output logic             io_oe_o,
	output logic             pullup_en_o,
	output logic             low_voltage_buffer_o,
	output logic             cmd_mode_o,
	output logic             user_reset_o,
	// Configuration memory write port
	output logic             cfg_we_o,
	output logic [7:0]       cfg_wdata_o
);
	typedef struct packed {
		cml_state_t   state;
		logic [31:0]  cnt;
		cml_scheme_t  scheme;
		logic         comp;
		logic         enc;
		logic         enh;
		logic         remote;
		logic         local_req;
		logic         hold;
		logic         reload_sw;
		logic [15:0]  length;
		logic [15:0]  count;
		logic [127:0] key;
		logic [3:0]   kidx;
		logic         first;
		logic [7:0]   shift;
		logic [2:0]   bitc;
		logic [1:0]   sub;
		logic [5:0]   rep;
		logic         we;
		logic [7:0]   wdata;
		logic         clk_prev;
		logic         chain_out_n;
		logic         bufsel;
		logic         fail;
		logic         ack;
		logic [31:0]  rdata;
	} cml_core_t;

	localparam cml_core_t CORE_RST = '{
		state:       CML_ST_POR,
		scheme:      CML_SCHEME_RST,
		length:      CML_LENGTH_RST,
		first:       1'b1,
		chain_out_n: 1'b1,
		default:     '0
	};

	cml_core_t   s;
	cml_core_t   n;
	cml_pins_t   pin;
	logic [$bits(cml_pins_t)-1:0] pin_q;
	logic        as_en;
	logic        as_rise;
	logic        lclk_rise;
	logic        bus_req;
	logic        wr_go;
	logic        stall;
	logic        take;
	logic        sbit;
	logic [7:0]  word;
	logic [7:0]  dec;
	logic        comp_eff;
	logic        enc_eff;
	logic        slow;
	logic        local_eff;
	logic        reload_hit;
	logic [31:0] por_target;
	logic [31:0] rd_word;

	if (POR_SHORT_CYC < 1 || POR_LONG_CYC < 1) begin : g_chk
		$error("cml_loader: power-on delays must be at least one cycle");
	end

	// All pins cross into the core clock first
	cml_sync #(
		.W($bits(cml_pins_t))
	) u_sync (
		.core_clk_i(core_clk_i),
		.rst_i     (rst_i),
		.d_i       (pins_i),
		.q_o       (pin_q)
	);
	assign pin = cml_pins_t'(pin_q);

	assign as_en = (s.state == CML_ST_LOAD) &&
		(s.scheme == CML_SCH_SELF_SERIAL) && !pin.chain_load_enable_in_n;
	cml_div #(
		.HALF(CML_SERIAL_HALF_CYC)
	) u_div (
		.core_clk_i(core_clk_i),
		.rst_i     (rst_i),
		.en_i      (as_en),
		.clk_o     (load_clock_o),
		.rise_o    (as_rise)
	);

	// Edge seen on the synchronised link clock
	assign lclk_rise = pin.load_clock && !s.clk_prev;

	assign comp_eff = s.comp && !(s.scheme == CML_SCH_FAST_PARALLEL && s.enh)
		&& (s.scheme inside {CML_SCH_FAST_PARALLEL, CML_SCH_SELF_SERIAL,
		CML_SCH_PASSIVE_SER});
	assign enc_eff = s.enc && !(s.scheme == CML_SCH_FAST_PARALLEL && s.enh)
		&& (s.scheme inside {CML_SCH_FAST_PARALLEL, CML_SCH_SELF_SERIAL,
		CML_SCH_PASSIVE_SER});
	assign slow = (s.scheme == CML_SCH_FAST_PARALLEL) && (comp_eff || enc_eff);
	assign local_eff = s.local_req && (s.scheme != CML_SCH_SELF_SERIAL);

	assign por_target = pin.reset_delay_select ? 32'(POR_SHORT_CYC)
		: 32'(POR_LONG_CYC);

	// Bus handshake; data writes wait while a run is expanding
	assign bus_req = av_i.read || av_i.write;
	assign stall   = av_i.write && (av_i.address == CML_REG_DATA) &&
		(s.rep != 6'h00);
	assign wr_go   = av_i.write && s.ack;
	assign reload_hit = !pin.reload_request_n || s.reload_sw;

	assign dec = enc_eff ? (word ^ s.key[{s.kidx, 3'h0} +: 8]) : word;

	always_comb begin
		n          = s;
		n.we       = 1'b0;
		n.ack      = 1'b0;
		n.clk_prev = pin.load_clock;
		take       = 1'b0;
		sbit       = 1'b0;
		word       = 8'h00;
		rd_word    = 32'h0000_0000;
		// Read mux; key and data are write-only
		case (av_i.address)
			CML_REG_CTRL: begin
				rd_word = {21'h0, s.reload_sw, 1'b0, s.hold, s.local_req,
					s.remote, s.enh, s.enc, s.comp, s.scheme};
			end
			CML_REG_STATUS: begin
				rd_word = {20'h0, !s.chain_out_n, s.hold, local_eff, s.fail,
					s.bufsel, cmd_mode_o, s.state};
			end
			CML_REG_LENGTH: rd_word = {16'h0, s.length};
			CML_REG_COUNT:  rd_word = {16'h0, s.count};
			default:        rd_word = 32'h0000_0000;
		endcase
		// Request answered one cycle after it appears
		if (bus_req && !s.ack && !stall) begin
			n.ack   = 1'b1;
			n.rdata = rd_word;
		end
		// Register writes take effect at the accepting edge
		if (wr_go) begin
			case (av_i.address)
				CML_REG_CTRL: begin
					n.scheme    = cml_scheme_t'(av_i.writedata[CML_C_SCHEME +: 3]);
					n.comp      = av_i.writedata[CML_C_COMP];
					n.enc       = av_i.writedata[CML_C_ENC];
					n.enh       = av_i.writedata[CML_C_ENH];
					n.remote    = av_i.writedata[CML_C_REMOTE];
					n.local_req = av_i.writedata[CML_C_LOCAL];
					if (av_i.writedata[CML_C_UPDATE])
						n.hold = 1'b0;
					if (av_i.writedata[CML_C_HOLD])
						n.hold = 1'b1;
					if (av_i.writedata[CML_C_RELOAD] && s.remote)
						n.reload_sw = 1'b1;
				end
				CML_REG_LENGTH: n.length = av_i.writedata[15:0];
				default: begin
					if ((av_i.address & CML_REG_KEY_MASK) == CML_REG_KEY)
						n.key[{av_i.address[3:2], 5'h00} +: 32] =
							av_i.writedata;
				end
			endcase
		end
		if (s.state == CML_ST_LOAD && !pin.chain_load_enable_in_n &&
			!s.hold) begin
			case (s.scheme)
				CML_SCH_FAST_PARALLEL: begin
					if (lclk_rise) begin
						n.sub = s.sub + 2'h1;
						if (!slow || s.sub == CML_WIDE_LAST) begin
							take = 1'b1;
							word = pin.data;
						end
					end
				end
				CML_SCH_PASSIVE_SER: sbit = lclk_rise;
				CML_SCH_JTAG:        sbit = lclk_rise;
				CML_SCH_SELF_SERIAL: sbit = as_rise;
				CML_SCH_ASYNC_PAR: begin
					if (wr_go && av_i.address == CML_REG_DATA) begin
						take = 1'b1;
						word = av_i.writedata[7:0];
					end
				end
				default: take = 1'b0;
			endcase
		end
		// Serial bits arrive LSB first
		if (sbit) begin
			n.shift = {pin.data[0], s.shift[7:1]};
			n.bitc  = s.bitc + 3'h1;
			if (s.bitc == 3'h7) begin
				take = 1'b1;
				word = {pin.data[0], s.shift[7:1]};
			end
		end
		case (s.state)
			CML_ST_POR: begin
				n.cnt = s.cnt + 32'h1;
				if (s.cnt + 32'h1 >= por_target) begin
					n.cnt   = 32'h0;
					n.state = CML_ST_LOAD;
					n.bufsel = pin.config_input_buffer_select;
				end
			end
			CML_ST_CLEAR: begin
				n.count       = 16'h0;
				n.kidx        = 4'h0;
				n.first       = 1'b1;
				n.rep         = 6'h00;
				n.bitc        = 3'h0;
				n.sub         = 2'h0;
				n.fail        = 1'b0;
				// A pending soft reload is cleared here, even if another is written in this very cycle
				n.reload_sw   = n.reload_sw && !s.reload_sw;
				n.chain_out_n = 1'b1;
				if (pin.reload_request_n && !s.reload_sw)
					n.state = CML_ST_LOAD;
			end
			CML_ST_LOAD: begin
				if (s.count == s.length) begin
					n.rep   = 6'h00;
					n.cnt   = 32'h0;
					n.state = CML_ST_INIT;
				end else if (take) begin
					if (enc_eff)
						n.kidx = s.kidx + 4'h1;
					if (enc_eff && s.first) begin
						n.first = 1'b0;
						if (dec != CML_SYNC_WORD) begin
							n.fail  = 1'b1;
							n.state = CML_ST_FAIL;
						end
					end else if (comp_eff && dec[7]) begin
						n.rep = {1'b0, dec[4:0]} + 6'h01;
					end else begin
						n.we    = 1'b1;
						n.wdata = dec;
						n.count = s.count + 16'h1;
					end
				end else if (s.rep != 6'h00) begin
					n.we    = 1'b1;
					n.wdata = 8'h00;
					n.rep   = s.rep - 6'h01;
					n.count = s.count + 16'h1;
				end
			end
			CML_ST_INIT: begin
				n.cnt         = s.cnt + 32'h1;
				n.chain_out_n = 1'b0;
				if (s.cnt == 32'(CML_INIT_CYC - 1))
					n.state = CML_ST_USER;
			end
			CML_ST_USER: n.cnt = 32'h0;
			CML_ST_FAIL: n.cnt = 32'h0;
			default:     n.state = CML_ST_POR;
		endcase
		if (reload_hit && (s.state inside {CML_ST_LOAD, CML_ST_USER,
			CML_ST_FAIL}))
			n.state = CML_ST_CLEAR;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= CORE_RST;
		end else begin
			s <= n;
		end
	end

	assign cmd_mode_o = (s.state != CML_ST_USER);
	assign io_oe_o = !cmd_mode_o;
	assign pullup_en_o = cmd_mode_o && !pin.preload_pullup_disable;
	assign load_status_out_o = !(s.hold || (s.state inside {CML_ST_POR,
		CML_ST_CLEAR, CML_ST_FAIL}));
	assign user_reset_o              = (s.state == CML_ST_INIT);
	assign load_clock_oe_o           = as_en;
	assign chain_load_enable_out_n_o = s.chain_out_n;
	assign low_voltage_buffer_o      = s.bufsel;
	assign cfg_we_o                  = s.we;
	assign cfg_wdata_o               = s.wdata;
	assign av_waitrequest_o          = bus_req && !s.ack;
	assign av_readdata_o             = s.rdata;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	property p_io_hiz;
		cmd_mode_o |-> !io_oe_o && !user_reset_o || s.state == CML_ST_INIT;
	endproperty
	a_io_hiz: assert property (p_io_hiz)
		else $error("I/O enabled in command mode");

	property p_por_hold;
		(s.state == CML_ST_POR && s.cnt + 32'h1 < por_target)
			|=> (s.state == CML_ST_POR);
	endproperty
	a_por_hold: assert property (p_por_hold)
		else $error("Power-on delay ended early");

	property p_init;
		$rose(s.state == CML_ST_INIT)
			|-> user_reset_o [*8] ##1 (io_oe_o && !user_reset_o);
	endproperty
	a_init: assert property (p_init)
		else $error("Initialization length wrong");

	property p_full;
		$rose(s.state == CML_ST_INIT) |-> (s.count == s.length);
	endproperty
	a_full: assert property (p_full)
		else $error("Initialization before full image");

	property p_reload;
		(s.state == CML_ST_USER && !pin.reload_request_n)
			|=> (s.state == CML_ST_CLEAR) ##1 !io_oe_o;
	endproperty
	a_reload: assert property (p_reload)
		else $error("Reload request not obeyed");

	property p_pullup;
		(cmd_mode_o && !pin.preload_pullup_disable) |-> pullup_en_o;
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("Pull-ups off in command mode");

	property p_bufsel;
		(s.state != CML_ST_POR) |=> $stable(low_voltage_buffer_o);
	endproperty
	a_bufsel: assert property (p_bufsel)
		else $error("Buffer select changed after power-up");

	property p_chain;
		(s.state == CML_ST_LOAD && pin.chain_load_enable_in_n &&
			s.rep == 6'h00) |=> !cfg_we_o;
	endproperty
	a_chain: assert property (p_chain)
		else $error("Data taken without enable-in");

	property p_dec;
		(s.state == CML_ST_LOAD && s.rep != 6'h00 && s.count != s.length
			&& !reload_hit) |=> cfg_we_o && cfg_wdata_o == 8'h00;
	endproperty
	a_dec: assert property (p_dec)
		else $error("Run expansion stalled");

	property p_cfgio;
		s.hold |-> !load_status_out_o;
	endproperty
	a_cfgio: assert property (p_cfgio)
		else $error("Status released while I/O held");

	property p_self;
		as_en |-> ##[1:12] (load_clock_o || !as_en);
	endproperty
	a_self: assert property (p_self)
		else $error("Self-driven load clock idle");
endmodule

// ===== logic/cml_pkg.sv
package cml_pkg;
	// Widths
	localparam int CML_AW = 6;
	localparam int CML_DW = 8;
	// Time base at 250 MHz
	localparam int CML_CLK_PERIOD_NS = 4;
	localparam int CML_NS_PER_MS = 1000000;
	localparam int CML_MS_CYC = CML_NS_PER_MS / CML_CLK_PERIOD_NS;
	localparam int CML_POR_LONG_MS = 100;
	localparam int CML_POR_SHORT_MS = 12;
	localparam int CML_POR_LONG_CYC = CML_POR_LONG_MS * CML_MS_CYC;
	localparam int CML_POR_SHORT_CYC = CML_POR_SHORT_MS * CML_MS_CYC;
	// Self-driven serial clock, half period
	localparam int CML_SERIAL_HALF_NS = 20;
	localparam int CML_SERIAL_HALF_CYC =
		CML_SERIAL_HALF_NS / CML_CLK_PERIOD_NS;
	// Initialization length and slow parallel word ratio
	localparam int CML_INIT_CYC = 8;
	localparam logic [1:0] CML_WIDE_LAST = 2'h3;
	// Header every encrypted stream must decrypt to
	localparam logic [7:0] CML_SYNC_WORD = 8'hA5;
	// Register byte offsets
	localparam logic [5:0] CML_REG_CTRL = 6'h00;
	localparam logic [5:0] CML_REG_STATUS = 6'h04;
	localparam logic [5:0] CML_REG_LENGTH = 6'h08;
	localparam logic [5:0] CML_REG_DATA = 6'h0C;
	localparam logic [5:0] CML_REG_KEY = 6'h10;
	localparam logic [5:0] CML_REG_KEY_MASK = 6'h30;
	localparam logic [5:0] CML_REG_COUNT = 6'h20;
	// Control register field positions
	localparam int CML_C_SCHEME = 0;
	localparam int CML_C_COMP = 3;
	localparam int CML_C_ENC = 4;
	localparam int CML_C_ENH = 5;
	localparam int CML_C_REMOTE = 6;
	localparam int CML_C_LOCAL = 7;
	localparam int CML_C_HOLD = 8;
	localparam int CML_C_UPDATE = 9;
	localparam int CML_C_RELOAD = 10;
	// Values after reset
	localparam logic [15:0] CML_LENGTH_RST = 16'h0100;
	typedef enum logic [2:0] {
		CML_SCH_FAST_PARALLEL = 3'h0,
		CML_SCH_SELF_SERIAL   = 3'h1,
		CML_SCH_PASSIVE_SER   = 3'h2,
		CML_SCH_ASYNC_PAR     = 3'h3,
		CML_SCH_JTAG          = 3'h4
	} cml_scheme_t;
	localparam cml_scheme_t CML_SCHEME_RST = CML_SCH_SELF_SERIAL;
	typedef enum logic [5:0] {
		CML_ST_POR   = 6'h01,
		CML_ST_CLEAR = 6'h02,
		CML_ST_LOAD  = 6'h04,
		CML_ST_INIT  = 6'h08,
		CML_ST_USER  = 6'h10,
		CML_ST_FAIL  = 6'h20
	} cml_state_t;
	// Avalon-MM request from the master
	typedef struct packed {
		logic        read;
		logic        write;
		logic [5:0]  address;
		logic [31:0] writedata;
	} cml_av_req_t;
	// Configuration pins seen from outside
	typedef struct packed {
		logic       reset_delay_select;
		logic       preload_pullup_disable;
		logic       config_input_buffer_select;
		logic       chain_load_enable_in_n;
		logic       reload_request_n;
		logic       load_clock;
		logic [7:0] data;
	} cml_pins_t;
endpackage

// ===== logic/cml_sync.sv
`timescale 1ns/1ps
module cml_sync
	import cml_pkg::*;
#(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         rst_i,
	// Asynchronous in, synchronous out
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} cml_sync_t;

	cml_sync_t s;
	cml_sync_t next_s;

	if (W < 1) begin : g_chk
		$error("cml_sync: W must be at least 1");
	end

	// Meta stage feeds only the second stage
	always_comb begin
		next_s.meta = d_i;
		next_s.q    = s.meta;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q_o = s.q;
endmodule
